// ===== logic/bsc_tap.sv
`timescale 1ns/1ps
`include "bsc_cfg.svh"

// Behaviour
// - Five rising tck edges with tms high always reach Test-Logic-Reset
// - No power-up self reset; tester resets via trst_n or tms
// - All state changes on rising tck, steered by sampled tms
// - Run-Test-Idle does nothing unless the instruction needs it
// - Select-DR-Scan goes to capture-DR or Select-IR-Scan by tms
// - Select-IR-Scan goes to capture-IR or back to reset by tms
// - Capture-IR loads a fixed pattern ending in binary 01
// - Shift-IR moves instruction bits from tdi toward tdo
// - Exit1-IR branches to pause or update; pause holds the bits
// - Exit2-IR goes back to shift or on to update by tms
// - Update-IR latches the new instruction on falling tck
// - Capture-DR loads the data register chosen by the instruction
// - Data path states mirror the instruction path on the data register
// - Four-bit instruction, least significant bit nearest tdo
// - Codes 0,1 boundary; 2 identity; 4 high-z; f bypass
// - Three data registers share tdi and tdo, instruction picks one
// - Bypass stage clears to zero in Capture-DR when selected
// - Bypass and unselected registers leave normal function alone
// - Identity word: version, part, maker, bit zero set
// - Maker field holds the eleven-bit code without parity
// - External test drives pins from and captures into boundary cells
// - High-z instruction disables all outputs and uses bypass
// - Sample/preload keeps normal function while sampling pins
// - Identity register selected straight after reset

module bsc_tap #(
  // Identity values are arbitrary
  parameter logic [`BSC_ID_VER_W-1:0] ID_VERSION = 4'h1,
  parameter logic [`BSC_ID_PART_W-1:0] ID_PART = 16'h0abc,
  parameter logic [`BSC_ID_MAKER_W-1:0] ID_MAKER = 11'h055
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire bsc_pkg::bsc_pad_t core_drv,
  input wire logic [`BSC_IO_W-1:0] pad_in,
  output bsc_pkg::bsc_pad_t pad_drv,
  output logic [`BSC_IO_W-1:0] core_in,
  output logic tap_reset
);

  // Identity word assembled from its fields
  // fixed identity layout
  localparam logic [`BSC_ID_W-1:0] ID_WORD =
    {ID_VERSION, ID_PART, ID_MAKER, `BSC_ID_FIXED_LSB};

  bsc_pkg::bsc_state_t state;
  bsc_pkg::bsc_state_t next_state;
  bsc_pkg::bsc_dr_sel_t dr_sel;
  logic [`BSC_IR_W-1:0] ir_shift;
  logic [`BSC_IR_W-1:0] ir;
  logic bypass;
  logic [`BSC_ID_W-1:0] id_shift;
  logic extest;
  logic hiz;
  logic shifting;
  logic next_so;
  logic tlr_q;
  logic [1:0] mode_q;
  logic upd_tog;
  logic [`BSC_BSR_W-1:0] cap_meta;
  logic [`BSC_BSR_W-1:0] cap_sync;
  logic [`BSC_BSR_W-1:0] bsr_upd;
  logic bsr_so;

  logic tlr_meta;
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  logic [2:0] tog_sync;
  logic [`BSC_BSR_W-1:0] upd_word;
  logic [`BSC_IO_W-1:0] pin_meta;

  // ---------------- Controller (tck domain) ----------------

  always_comb begin
    next_state = state;
    case (state)
      bsc_pkg::ST_TLR: begin
        next_state = tms ? bsc_pkg::ST_TLR : bsc_pkg::ST_RTI;
      end
      bsc_pkg::ST_RTI: begin
        next_state = tms ? bsc_pkg::ST_SEL_DR : bsc_pkg::ST_RTI;
      end
      bsc_pkg::ST_SEL_DR: begin
        next_state = tms ? bsc_pkg::ST_SEL_IR : bsc_pkg::ST_CAP_DR;
      end
      bsc_pkg::ST_CAP_DR: begin
        next_state = tms ? bsc_pkg::ST_EXIT1_DR : bsc_pkg::ST_SHIFT_DR;
      end
      bsc_pkg::ST_SHIFT_DR: begin
        next_state = tms ? bsc_pkg::ST_EXIT1_DR : bsc_pkg::ST_SHIFT_DR;
      end
      bsc_pkg::ST_EXIT1_DR: begin
        next_state = tms ? bsc_pkg::ST_UPD_DR : bsc_pkg::ST_PAUSE_DR;
      end
      bsc_pkg::ST_PAUSE_DR: begin
        next_state = tms ? bsc_pkg::ST_EXIT2_DR : bsc_pkg::ST_PAUSE_DR;
      end
      bsc_pkg::ST_EXIT2_DR: begin
        next_state = tms ? bsc_pkg::ST_UPD_DR : bsc_pkg::ST_SHIFT_DR;
      end
      bsc_pkg::ST_UPD_DR: begin
        next_state = tms ? bsc_pkg::ST_SEL_DR : bsc_pkg::ST_RTI;
      end
      // IR path or back to reset
      bsc_pkg::ST_SEL_IR: begin
        next_state = tms ? bsc_pkg::ST_TLR : bsc_pkg::ST_CAP_IR;
      end
      bsc_pkg::ST_CAP_IR: begin
        next_state = tms ? bsc_pkg::ST_EXIT1_IR : bsc_pkg::ST_SHIFT_IR;
      end
      bsc_pkg::ST_SHIFT_IR: begin
        next_state = tms ? bsc_pkg::ST_EXIT1_IR : bsc_pkg::ST_SHIFT_IR;
      end
      bsc_pkg::ST_EXIT1_IR: begin
        next_state = tms ? bsc_pkg::ST_UPD_IR : bsc_pkg::ST_PAUSE_IR;
      end
      bsc_pkg::ST_PAUSE_IR: begin
        next_state = tms ? bsc_pkg::ST_EXIT2_IR : bsc_pkg::ST_PAUSE_IR;
      end
      bsc_pkg::ST_EXIT2_IR: begin
        next_state = tms ? bsc_pkg::ST_UPD_IR : bsc_pkg::ST_SHIFT_IR;
      end
      bsc_pkg::ST_UPD_IR: begin
        next_state = tms ? bsc_pkg::ST_SEL_DR : bsc_pkg::ST_RTI;
      end
      default: begin
        next_state = bsc_pkg::ST_TLR;
      end
    endcase
  end

  // No power-up initial value: state is known only after trst_n or tms
  // tms sequence reaches reset
  // reset only by trst_n or tms
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state <= bsc_pkg::ST_TLR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_shift <= `BSC_IR_CAPTURE;
    end else if (state == bsc_pkg::ST_CAP_IR) begin
      ir_shift <= `BSC_IR_CAPTURE;
    end else if (state == bsc_pkg::ST_SHIFT_IR) begin
      ir_shift <= {tdi, ir_shift[`BSC_IR_W-1:1]};
    end
  end

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir <= `BSC_IR_RESET;
    end else if (state == bsc_pkg::ST_TLR) begin
      ir <= `BSC_IR_RESET;
    end else if (state == bsc_pkg::ST_UPD_IR) begin
      ir <= ir_shift;
    end
  end

  always_comb begin
    case (ir)
      `BSC_IR_EXTEST: dr_sel = bsc_pkg::DR_BSR;
      `BSC_IR_SAMPLE: dr_sel = bsc_pkg::DR_BSR;
      `BSC_IR_IDCODE: dr_sel = bsc_pkg::DR_ID;
      default: dr_sel = bsc_pkg::DR_BYPASS;
    endcase
  end

  assign extest = (ir == `BSC_IR_EXTEST);
  assign hiz = (ir == `BSC_IR_HIGHZ);

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bypass <= `BSC_BYPASS_RST;
    end else if (dr_sel == bsc_pkg::DR_BYPASS) begin
      if (state == bsc_pkg::ST_CAP_DR) begin
        bypass <= 1'b0;
      end else if (state == bsc_pkg::ST_SHIFT_DR) begin
        bypass <= tdi;
      end
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      id_shift <= '0;
    end else if (dr_sel == bsc_pkg::DR_ID) begin
      if (state == bsc_pkg::ST_CAP_DR) begin
        id_shift <= ID_WORD;
      end else if (state == bsc_pkg::ST_SHIFT_DR) begin
        id_shift <= {tdi, id_shift[`BSC_ID_W-1:1]};
      end
    end
  end

  // Pin and core values come from other domains: two stages first
  // sample functional pins
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      cap_meta <= '0;
      cap_sync <= '0;
    end else begin
      cap_meta <= {core_drv, pad_in};
      cap_sync <= cap_meta;
    end
  end

  bsc_bsr u_bsr (
    .tck(tck),
    .trst_n(trst_n),
    .capture((state == bsc_pkg::ST_CAP_DR) && (dr_sel == bsc_pkg::DR_BSR)),
    .shift((state == bsc_pkg::ST_SHIFT_DR) && (dr_sel == bsc_pkg::DR_BSR)),
    .update((state == bsc_pkg::ST_UPD_DR) && (dr_sel == bsc_pkg::DR_BSR)),
    .tdi(tdi),
    .cap_data(cap_sync),
    .so(bsr_so),
    .upd_data(bsr_upd)
  );

  // Toggle marks each boundary update for the mclk side
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      upd_tog <= 1'b0;
    end else if ((state == bsc_pkg::ST_UPD_DR) &&
                 (dr_sel == bsc_pkg::DR_BSR)) begin
      upd_tog <= ~upd_tog;
    end
  end

  // Registered levels so the crossing never sees a decode glitch
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tlr_q <= 1'b1;
      mode_q <= 2'h0;
    end else begin
      tlr_q <= (next_state == bsc_pkg::ST_TLR);
      mode_q <= {hiz, extest};
    end
  end

  // one serial path, instruction picks it
  always_comb begin
    shifting = (state == bsc_pkg::ST_SHIFT_IR) ||
               (state == bsc_pkg::ST_SHIFT_DR);
    case (dr_sel)
      bsc_pkg::DR_BSR: next_so = bsr_so;
      bsc_pkg::DR_ID: next_so = id_shift[0];
      default: next_so = bypass;
    endcase
    if (state == bsc_pkg::ST_SHIFT_IR) begin
      next_so = ir_shift[0];
    end
  end

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo <= `BSC_TDO_RST;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo <= next_so;
      tdo_oe_n <= ~shifting;
    end
  end

  // ---------------- Pin side (mclk domain) ----------------

  always_ff @(posedge mclk) begin
    if (rst) begin
      tlr_meta <= 1'b1;
      tap_reset <= 1'b1;
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
      tog_sync <= 3'h0;
      pin_meta <= '0;
      core_in <= '0;
    end else begin
      tlr_meta <= tlr_q;
      tap_reset <= tlr_meta;
      mode_meta <= mode_q;
      mode_sync <= mode_meta;
      tog_sync <= {tog_sync[1:0], upd_tog};
      pin_meta <= pad_in;
      core_in <= pin_meta;
    end
  end

  // Word is stable for many mclk cycles after its toggle arrives
  always_ff @(posedge mclk) begin
    if (rst) begin
      upd_word <= '0;
      upd_word[`BSC_BSR_OE_BIT] <= 1'b1;
    end else if (tog_sync[2] != tog_sync[1]) begin
      upd_word <= bsr_upd;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pad_drv <= {1'b1, {`BSC_IO_W{1'b0}}};
    end else if (mode_sync[1]) begin
      pad_drv <= {1'b1, core_drv.data};
    end else if (mode_sync[0]) begin
      pad_drv <= upd_word[`BSC_BSR_W-1:`BSC_BSR_OUT_LSB];
    end else begin
      pad_drv <= core_drv;
    end
  end

  // core holds queues while tap_reset is low

  // ---------------- Checks ----------------

  sequence s_tms_held;
    tms [*5];
  endsequence

  sequence s_ir_load;
    (state == bsc_pkg::ST_CAP_IR) ##1 (state != bsc_pkg::ST_CAP_IR);
  endsequence

  a_five_tms_reset: assert property (
    @(posedge tck) disable iff (!trst_n)
    s_tms_held |=> (state == bsc_pkg::ST_TLR))
    else $error("five tms highs did not reach reset");

  a_rti_step: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_RTI) && tms |=> (state == bsc_pkg::ST_SEL_DR))
    else $error("idle with tms high did not go to select-dr");

  a_sel_dr_branch: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_SEL_DR) && !tms |=>
      (state == bsc_pkg::ST_CAP_DR))
    else $error("select-dr with tms low did not capture");

  a_sel_ir_back: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_SEL_IR) && tms |=> (state == bsc_pkg::ST_TLR))
    else $error("select-ir with tms high did not reset");

  a_capture_ir_pattern: assert property (
    @(posedge tck) disable iff (!trst_n)
    s_ir_load |-> (ir_shift[1:0] == 2'b01))
    else $error("capture-ir pattern wrong");

  a_shift_ir_data: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_SHIFT_IR) |=>
      (ir_shift == {$past(tdi), $past(ir_shift[3:1])}))
    else $error("shift-ir moved the wrong bits");

  a_pause_ir_hold: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_PAUSE_IR) |=> $stable(ir_shift))
    else $error("pause-ir changed the shift stages");

  a_exit2_ir_branch: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_EXIT2_IR) && !tms |=>
      (state == bsc_pkg::ST_SHIFT_IR))
    else $error("exit2-ir with tms low did not shift");

  a_update_ir_latch: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_UPD_IR) |=> (ir == $past(ir_shift)))
    else $error("update-ir did not latch the instruction");

  a_bypass_clear: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_CAP_DR) && (dr_sel == bsc_pkg::DR_BYPASS)
      |=> (bypass == 1'b0))
    else $error("bypass not cleared in capture-dr");

  a_id_capture: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_CAP_DR) && (dr_sel == bsc_pkg::DR_ID)
      |=> (id_shift == ID_WORD) && id_shift[0])
    else $error("identity word not captured");

  a_reset_selects_id: assert property (
    @(posedge tck) disable iff (!trst_n)
    (state == bsc_pkg::ST_TLR) |=> (dr_sel == bsc_pkg::DR_ID))
    else $error("identity not selected after reset");

  a_tdo_release: assert property (
    @(posedge tck) disable iff (!trst_n)
    !shifting |-> tdo_oe_n)
    else $error("tdo driven outside shift states");

  a_hiz_outputs_off: assert property (
    @(posedge mclk) disable iff (rst)
    mode_sync[1] |=> pad_drv.oe_n)
    else $error("outputs enabled under high-z");

endmodule

// ===== logic/bsc_cfg.svh
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// Instruction register
`define BSC_IR_W 4
`define BSC_IR_EXTEST 4'h0
`define BSC_IR_SAMPLE 4'h1
`define BSC_IR_IDCODE 4'h2
`define BSC_IR_HIGHZ 4'h4
`define BSC_IR_BYPASS 4'hf
`define BSC_IR_CAPTURE 4'h1
`define BSC_IR_RESET `BSC_IR_IDCODE

// Identification word layout
`define BSC_ID_W 32
`define BSC_ID_VER_W 4
`define BSC_ID_PART_W 16
`define BSC_ID_MAKER_W 11
`define BSC_ID_FIXED_LSB 1'b1

// Boundary cells: inputs [7:0], output data [15:8], output enable [16]
`define BSC_IO_W 8
`define BSC_BSR_W 17
`define BSC_BSR_OUT_LSB 8
`define BSC_BSR_OE_BIT 16

// Reset values
`define BSC_BYPASS_RST 1'b0
`define BSC_TDO_RST 1'b0

`endif

// ===== logic/bsc_pkg.sv
`include "bsc_cfg.svh"

package bsc_pkg;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bsc_state_t;

  typedef enum logic [1:0] {
    DR_BYPASS, DR_BSR, DR_ID
  } bsc_dr_sel_t;

  // One group of output pins with a shared enable (low = driving)
  typedef struct packed {
    logic oe_n;
    logic [`BSC_IO_W-1:0] data;
  } bsc_pad_t;

endpackage

// ===== logic/bsc_bsr.sv
`timescale 1ns/1ps
`include "bsc_cfg.svh"

module bsc_bsr (
  input wire logic tck,
  input wire logic trst_n,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic tdi,
  input wire logic [`BSC_BSR_W-1:0] cap_data,
  output logic so,
  output logic [`BSC_BSR_W-1:0] upd_data
);

  logic [`BSC_BSR_W-1:0] chain;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      chain <= '0;
    end else if (capture) begin
      chain <= cap_data;
    end else if (shift) begin
      chain <= {tdi, chain[`BSC_BSR_W-1:1]};
    end
  end

  assign so = chain[0];

  // Update cells change only on the falling edge so pins see no ripple
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      upd_data <= '0;
      upd_data[`BSC_BSR_OE_BIT] <= 1'b1;
    end else if (update) begin
      upd_data <= chain;
    end
  end

endmodule

// ===== testbench/bsc_jtag_host.sv
`timescale 1ns/1ps

module bsc_jtag_host (
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  int oe_bad;
  logic oe_seen;

  initial begin
    tck = 1'b0;
    trst_n = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    oe_bad = 0;
    oe_seen = 1'b1;
  end

  // One tck period; tdo is taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #15;
    q = tdo;
    oe_seen = tdo_oe_n;
    tck = 1'b1;
    #15;
    tck = 1'b0;
  endtask

  task automatic pin_reset;
    logic q;
    trst_n = 1'b0;
    #60;
    trst_n = 1'b1;
    #30;
    step(1'b0, ~tdi, q);
  endtask

  task automatic tms_reset;
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
  endtask

  // Scan from Run-Test-Idle, optional pause halfway, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input logic pause, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    step(1'b1, ~tdi, q);
    if (ir)
      step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || (pause && i == n / 2), din[i], q);
      dout[i] = q;
      if (oe_seen !== 1'b0)
        oe_bad++;
      if (pause && i == n / 2 && i != n - 1) begin
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
      end
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule

// ===== testbench/bsc_tap_tb.sv
`timescale 1ns/1ps
`include "bsc_cfg.svh"

module bsc_tap_tb;
  // Identity values are arbitrary
  localparam logic [3:0] TB_VER = 4'h3;
  localparam logic [15:0] TB_PART = 16'h1234;
  localparam logic [10:0] TB_MAKER = 11'h2aa;
  localparam logic [31:0] TB_ID = {TB_VER, TB_PART, TB_MAKER, 1'b1};
  localparam logic [8:0] TB_CORE = 9'h0c3;

  logic mclk, rst, tck, trst_n, tms, tdi, tdo, tdo_oe_n, tap_reset;
  bsc_pkg::bsc_pad_t core_drv, pad_drv;
  logic [8:0] pad_vec;
  logic [7:0] pad_in, core_in;
  int num_errors, check_count;

  assign pad_vec = pad_drv;

  bsc_tap #(.ID_VERSION(TB_VER), .ID_PART(TB_PART), .ID_MAKER(TB_MAKER)) DUT (
    .mclk(mclk), .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_drv(core_drv),
    .pad_in(pad_in), .pad_drv(pad_drv), .core_in(core_in),
    .tap_reset(tap_reset)
  );

  bsc_jtag_host host (
    .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n)
  );

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic summarize;
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pin side settles a few mclk after the tck update
  task automatic wait_pad(input logic [8:0] exp, input logic [8:0] mask);
    int n;
    n = 0;
    while ((pad_vec & mask) !== exp && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check({23'h0, pad_vec & mask}, {23'h0, exp});
  endtask

  task automatic wait_reset(input logic exp);
    int n;
    n = 0;
    while (tap_reset !== exp && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check({31'h0, tap_reset}, {31'h0, exp});
  endtask

  task automatic t_id_read;
    logic [31:0] d;
    host.pin_reset();
    host.scan(1'b0, 32, 32'h0, 1'b0, d);
    check(d, TB_ID);
    #5;
    check({31'h0, tdo_oe_n}, 32'h1);
  endtask

  task automatic t_bypass(input logic [3:0] code, input logic irp);
    logic [31:0] d;
    host.scan(1'b1, 4, {28'h0, code}, irp, d);
    check(d, {28'h0, `BSC_IR_CAPTURE});
    host.scan(1'b0, 8, 32'h96, 1'b1, d);
    check(d, 32'h2c);
    if (code == `BSC_IR_HIGHZ)
      wait_pad(9'h100, 9'h100);
    else
      wait_pad(TB_CORE, 9'h1ff);
  endtask

  task automatic t_boundary;
    logic [31:0] d;
    @(negedge mclk);
    pad_in = 8'ha5;
    host.scan(1'b1, 4, {28'h0, `BSC_IR_SAMPLE}, 1'b0, d);
    host.scan(1'b0, 17, 32'h05a00, 1'b0, d);
    check({24'h0, d[7:0]}, 32'ha5);
    check({24'h0, core_in}, 32'ha5);
    wait_pad(TB_CORE, 9'h1ff);
    host.scan(1'b1, 4, {28'h0, `BSC_IR_EXTEST}, 1'b0, d);
    wait_pad(9'h05a, 9'h1ff);
    host.scan(1'b0, 17, 32'h1ff00, 1'b0, d);
    check({24'h0, d[7:0]}, 32'ha5);
    wait_pad(9'h1ff, 9'h1ff);
  endtask

  task automatic t_tms_reset;
    logic [31:0] d;
    logic q;
    host.scan(1'b1, 4, {28'h0, `BSC_IR_BYPASS}, 1'b0, d);
    host.step(1'b1, ~tdi, q);
    host.step(1'b0, ~tdi, q);
    host.step(1'b0, ~tdi, q);
    host.tms_reset();
    wait_reset(1'b1);
    host.step(1'b0, ~tdi, q);
    wait_reset(1'b0);
    host.scan(1'b0, 32, 32'h0, 1'b0, d);
    check(d, TB_ID);
    host.step(1'b1, ~tdi, q);
    host.step(1'b1, ~tdi, q);
    host.step(1'b1, ~tdi, q);
    wait_reset(1'b1);
    host.step(1'b0, ~tdi, q);
  endtask

  initial begin
    rst = 1'b1;
    core_drv = TB_CORE;
    pad_in = 8'h3c;
    num_errors = 0;
    check_count = 0;
    repeat (10) @(negedge mclk);
    wait_pad(9'h100, 9'h1ff);
    rst = 1'b0;
    t_id_read();
    t_bypass(`BSC_IR_BYPASS, 1'b0);
    t_bypass(4'h7, 1'b1);
    t_bypass(`BSC_IR_HIGHZ, 1'b0);
    t_boundary();
    t_tms_reset();
    check(32'(host.oe_bad), 32'h0);
    summarize();
  end

  initial begin
    #500000;
    num_errors++;
    summarize();
  end
endmodule
